// ===== bmp_defs.vh
// constants for the boot mode programming port block
`ifndef BMP_DEFS_VH
`define BMP_DEFS_VH
`define BMP_BOOT_ADDR 16'h0000
`define BMP_REG_MODE 12'h000
`define BMP_REG_CTRL 12'h004
`define BMP_REG_STAT 12'h008
`define BMP_REG_TXD 12'h00C
`define BMP_REG_RXD 12'h010
`define BMP_REG_BAUD 12'h014
`define BMP_CTRL_ASYNC 0
`define BMP_CTRL_EIGHT 1
`define BMP_CTRL_GPIO_OE 2
`define BMP_CTRL_GPIO_OUT 3
`define BMP_CTRL_SFUNC_LO 4
`define BMP_CTRL_SFUNC_HI 5
`define BMP_CTRL_SLEVEL 6
`define BMP_CTRL_RST 32'h0000_0002
`define BMP_SFUNC_FETCH 2'h0
`define BMP_SFUNC_ACK 2'h1
`define BMP_SFUNC_GPO 2'h2
`define BMP_BAUD_MIN 16'h0008
`define BMP_BAUD_RST 16'h0008
`define BMP_FIFO_DEPTH 4
`define BMP_FIFO_AW 2
`define BMP_REL_WAIT 2'h2
`endif

// ===== bmp_fifo.v
// small valid/ready fifo in flip-flops
`timescale 1ns/1ps
`default_nettype none
module bmp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != DEPTH);
  assign out_valid = (cnt_r != 0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge mclk) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== bmp_port.v
// boot mode sampling, status pin and programming serial port
// How it works
// - reset release samples startup pins, picks boot
// - both pins high gives program mode
// - both pins low gives run mode
// - status low on first fetch after reset
// - status low during interrupt acknowledge cycles
// - status usable as software-set output
// - synchronous mode drives data and serial clock
// - async mode frees clock line as gpio
// - external reset restarts and resamples pins
// - async rate up to clock/8, 7 or 8 bits
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "bmp_defs.vh"
`default_nettype none
module bmp_port (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire reset_in_n,
  input wire startup_select_0,
  input wire startup_select_1,
  input wire first_fetch,
  input wire int_ack,
  output reg status_pin,
  output reg program_mode,
  output reg cold_boot,
  output wire [15:0] start_addr,
  output wire core_rst,
  output reg download_connector_port_transmit,
  input wire download_connector_port_receive,
  input wire download_connector_port_serial_clock_i,
  output reg download_connector_port_serial_clock_o,
  output reg download_connector_port_serial_clock_oe,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr
);
  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] rin_s_r, sm0_s_r, sm1_s_r, rx_s_r, sck_s_r;
  always @(posedge mclk) begin
    if (rst) begin
      rin_s_r <= 2'h3;
      sm0_s_r <= 2'h0;
      sm1_s_r <= 2'h0;
      rx_s_r <= 2'h3;
      sck_s_r <= 2'h0;
    end else if (ce) begin
      rin_s_r <= {rin_s_r[0], reset_in_n};
      sm0_s_r <= {sm0_s_r[0], startup_select_0};
      sm1_s_r <= {sm1_s_r[0], startup_select_1};
      rx_s_r <= {rx_s_r[0], download_connector_port_receive};
      sck_s_r <= {sck_s_r[0], download_connector_port_serial_clock_i};
    end
  end
  wire rx_in = rx_s_r[1];
  wire sck_in = sck_s_r[1];

  ////////////////////////////////////////////////////////////////
  // reset and boot mode
  // hold the core until the pin synchronisers carry fresh samples
  wire ext_rst = !rin_s_r[1];
  reg in_rst_r;
  reg [1:0] rel_r;
  reg fetch_seen_r;
  assign core_rst = in_rst_r;
  assign start_addr = `BMP_BOOT_ADDR;
  always @(posedge mclk) begin
    if (rst) begin
      in_rst_r <= 1'b1;
      rel_r <= 2'h0;
      program_mode <= 1'b0;
      cold_boot <= 1'b0;
    end else if (ce) begin
      if (ext_rst) begin
        in_rst_r <= 1'b1;
        rel_r <= 2'h0;
      end else if (in_rst_r && rel_r != `BMP_REL_WAIT) begin
        rel_r <= rel_r + 2'h1;
      end else if (in_rst_r) begin
        in_rst_r <= 1'b0;
        program_mode <= sm0_s_r[1] && sm1_s_r[1];
        cold_boot <= sm0_s_r[1] && sm1_s_r[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers
  reg [31:0] ctrl_r;
  reg [15:0] baud_r;
  wire async_m = ctrl_r[`BMP_CTRL_ASYNC];
  wire eight = ctrl_r[`BMP_CTRL_EIGHT];
  wire [1:0] sfunc = ctrl_r[`BMP_CTRL_SFUNC_HI:`BMP_CTRL_SFUNC_LO];
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire hit = (paddr == `BMP_REG_MODE) || (paddr == `BMP_REG_CTRL) ||
    (paddr == `BMP_REG_STAT) || (paddr == `BMP_REG_TXD) ||
    (paddr == `BMP_REG_RXD) || (paddr == `BMP_REG_BAUD);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  wire tx_in_ready, tx_valid, rx_valid, rx_in_ready;
  wire [7:0] tx_data, rx_data;
  reg tx_take;
  reg rx_push_r;
  reg [7:0] rx_byte_r;
  reg rx_ovr_r;
  wire tx_push = wr && (paddr == `BMP_REG_TXD);
  wire rx_pop = rd && (paddr == `BMP_REG_RXD);

  always @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= `BMP_CTRL_RST;
      baud_r <= `BMP_BAUD_RST;
    end else if (ce && wr) begin
      if (paddr == `BMP_REG_CTRL)
        ctrl_r <= {25'h0, pwdata[6:0]};
      if (paddr == `BMP_REG_BAUD)
        baud_r <= (pwdata[15:0] < `BMP_BAUD_MIN) ? `BMP_BAUD_MIN : pwdata[15:0];
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `BMP_REG_MODE: prdata = {30'h0, cold_boot, program_mode};
      `BMP_REG_CTRL: prdata = ctrl_r;
      `BMP_REG_STAT: prdata = {27'h0, sck_in, rx_ovr_r, rx_valid, !tx_in_ready, !tx_valid};
      `BMP_REG_RXD: prdata = {24'h0, rx_data};
      `BMP_REG_BAUD: prdata = {16'h0, baud_r};
      default: prdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // status pin
  always @(posedge mclk) begin
    if (rst) begin
      status_pin <= 1'b1;
      fetch_seen_r <= 1'b0;
    end else if (ce) begin
      if (in_rst_r)
        fetch_seen_r <= 1'b0;
      else if (first_fetch)
        fetch_seen_r <= 1'b1;
      case (sfunc)
        `BMP_SFUNC_FETCH: status_pin <= !(first_fetch && !fetch_seen_r && !in_rst_r);
        `BMP_SFUNC_ACK: status_pin <= !(int_ack && !in_rst_r);
        `BMP_SFUNC_GPO: status_pin <= ctrl_r[`BMP_CTRL_SLEVEL];
        default: status_pin <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // serial engine
  localparam ST_IDLE = 2'h0;
  localparam ST_XFER = 2'h1;
  localparam ST_STOP = 2'h2;
  reg [1:0] st_r;
  reg [15:0] div_r;
  reg [3:0] bit_r;
  reg [8:0] tsh_r;
  reg [7:0] rsh_r;
  reg [1:0] rst_st_r;
  reg [15:0] rdiv_r;
  reg [3:0] rbit_r;
  wire [3:0] nbits = eight ? 4'h8 : 4'h7;
  wire [15:0] half = {1'b0, baud_r[15:1]};

  always @* begin
    tx_take = (st_r == ST_IDLE) && tx_valid;
  end

  always @(posedge mclk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      div_r <= 16'h0000;
      bit_r <= 4'h0;
      tsh_r <= 9'h1FF;
      download_connector_port_transmit <= 1'b1;
      download_connector_port_serial_clock_o <= 1'b0;
      download_connector_port_serial_clock_oe <= 1'b0;
    end else if (ce) begin
      download_connector_port_serial_clock_oe <= async_m ? ctrl_r[`BMP_CTRL_GPIO_OE] : 1'b1;
      if (async_m)
        download_connector_port_serial_clock_o <= ctrl_r[`BMP_CTRL_GPIO_OUT];
      case (st_r)
        ST_IDLE: begin
          div_r <= 16'h0000;
          bit_r <= 4'h0;
          if (!async_m)
            download_connector_port_serial_clock_o <= 1'b1;
          if (tx_valid) begin
            st_r <= ST_XFER;
            if (async_m) begin
              download_connector_port_transmit <= 1'b0;
              tsh_r <= {1'b1, tx_data};
            end else begin
              download_connector_port_transmit <= tx_data[0];
              tsh_r <= {1'b1, tx_data};
              download_connector_port_serial_clock_o <= 1'b0;
            end
          end
        end
        ST_XFER: begin
          if (div_r == baud_r - 16'h0001) begin
            div_r <= 16'h0000;
            if (!async_m)
              download_connector_port_serial_clock_o <= (bit_r == 4'h7);
            if (async_m) begin
              download_connector_port_transmit <= (bit_r == nbits) ? 1'b1 : tsh_r[0];
              tsh_r <= {1'b1, tsh_r[8:1]};
              if (bit_r == nbits)
                st_r <= ST_STOP;
            end else begin
              tsh_r <= {1'b1, tsh_r[8:1]};
              download_connector_port_transmit <= tsh_r[1];
              if (bit_r == 4'h7)
                st_r <= ST_STOP;
            end
            bit_r <= bit_r + 4'h1;
          end else begin
            div_r <= div_r + 16'h0001;
            if (!async_m && div_r == half)
              download_connector_port_serial_clock_o <= 1'b1;
          end
        end
        ST_STOP: begin
          download_connector_port_transmit <= 1'b1;
          if (div_r == baud_r - 16'h0001) begin
            div_r <= 16'h0000;
            st_r <= ST_IDLE;
          end else
            div_r <= div_r + 16'h0001;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // receiver: async samples mid bit, sync samples on own clock rise
  always @(posedge mclk) begin
    if (rst) begin
      rst_st_r <= ST_IDLE;
      rdiv_r <= 16'h0000;
      rbit_r <= 4'h0;
      rsh_r <= 8'h00;
      rx_push_r <= 1'b0;
      rx_byte_r <= 8'h00;
      rx_ovr_r <= 1'b0;
    end else if (ce) begin
      rx_push_r <= 1'b0;
      if (rx_push_r && !rx_in_ready)
        rx_ovr_r <= 1'b1;
      else if (rd && paddr == `BMP_REG_STAT)
        rx_ovr_r <= 1'b0;
      if (!async_m) begin
        rst_st_r <= ST_IDLE;
        if (st_r == ST_XFER && div_r == half) begin
          rsh_r <= {rx_in, rsh_r[7:1]};
          if (bit_r == 4'h7) begin
            rx_byte_r <= {rx_in, rsh_r[7:1]};
            rx_push_r <= 1'b1;
          end
        end
      end else begin
        case (rst_st_r)
          ST_IDLE: begin
            rdiv_r <= 16'h0000;
            rbit_r <= 4'h0;
            if (!rx_in)
              rst_st_r <= ST_XFER;
          end
          ST_XFER: begin
            if (rdiv_r == baud_r - 16'h0001 || (rbit_r == 4'h0 && rdiv_r == half)) begin
              rdiv_r <= 16'h0000;
              rbit_r <= rbit_r + 4'h1;
              if (rbit_r == 4'h0 && rx_in)
                rst_st_r <= ST_IDLE;
              else if (rbit_r != 4'h0)
                rsh_r <= {rx_in, rsh_r[7:1]};
              if (rbit_r == nbits) begin
                rx_byte_r <= eight ? {rx_in, rsh_r[7:1]} : {1'b0, rx_in, rsh_r[7:2]};
                rx_push_r <= 1'b1;
                rst_st_r <= ST_STOP;
              end
            end else
              rdiv_r <= rdiv_r + 16'h0001;
          end
          ST_STOP: begin
            if (rx_in)
              rst_st_r <= ST_IDLE;
          end
          default: rst_st_r <= ST_IDLE;
        endcase
      end
    end
  end

  bmp_fifo #(.WIDTH(8), .DEPTH(`BMP_FIFO_DEPTH), .AW(`BMP_FIFO_AW)) u_txf (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(tx_valid),
    .out_ready(tx_take),
    .out_data(tx_data)
  );

  bmp_fifo #(.WIDTH(8), .DEPTH(`BMP_FIFO_DEPTH), .AW(`BMP_FIFO_AW)) u_rxf (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .in_valid(rx_push_r),
    .in_ready(rx_in_ready),
    .in_data(rx_byte_r),
    .out_valid(rx_valid),
    .out_ready(rx_pop),
    .out_data(rx_data)
  );

endmodule
`default_nettype wire

// ===== bmp_port_assertions.sv
// checker bound to the programming port top
`timescale 1ns/1ps
`default_nettype none
module bmp_port_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_in_n,
  input wire logic startup_select_0,
  input wire logic startup_select_1,
  input wire logic first_fetch,
  input wire logic int_ack,
  input wire logic status_pin,
  input wire logic program_mode,
  input wire logic cold_boot,
  input wire logic [15:0] start_addr,
  input wire logic core_rst,
  input wire logic download_connector_port_transmit,
  input wire logic download_connector_port_serial_clock_o,
  input wire logic download_connector_port_serial_clock_oe,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata
);
  reg [6:0] ctl_r;
  reg [1:0] hold_r;
  wire st = hold_r == 2'h2;
  wire [1:0] fn = ctl_r[5:4];
  // control shadow, settled two cycles after a write
  always @(posedge mclk) begin
    if (rst) begin
      ctl_r <= 7'h02;
      hold_r <= 2'h0;
    end else if (psel && penable && pwrite && paddr == 12'h004) begin
      ctl_r <= pwdata[6:0];
      hold_r <= 2'h0;
    end else if (hold_r != 2'h2) begin
      hold_r <= hold_r + 2'h1;
    end
  end
  ////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_boot_addr: assert property (start_addr == 16'h0000)
    else $error("start address not zero");
  a_mode_hold: assert property (!core_rst && !$past(core_rst) |-> $stable(program_mode))
    else $error("mode changed while running");
  a_download_connector_mode: assert property ($fell(core_rst) && startup_select_0 && startup_select_1
    |-> program_mode && cold_boot) else $error("program mode not entered");
  a_run_mode: assert property ($fell(core_rst) && !startup_select_0 && !startup_select_1
    |-> !program_mode && !cold_boot) else $error("run mode not entered");
  a_ext_reset: assert property (!reset_in_n [*6] |-> core_rst)
    else $error("external reset ignored");
  a_sync_clock: assert property (st && !ctl_r[0] |-> download_connector_port_serial_clock_oe)
    else $error("sync clock not driven");
  a_async_gpio: assert property (st && ctl_r[0] |-> download_connector_port_serial_clock_oe == ctl_r[2]
    && download_connector_port_serial_clock_o == ctl_r[3]) else $error("clock pin not gpio");
  a_gpo_level: assert property (st && fn == 2'h2 |-> status_pin == ctl_r[6])
    else $error("status level wrong");
  a_ack_low: assert property (st && fn == 2'h1 |-> status_pin == !$past(int_ack))
    else $error("status wrong around acknowledge");
  a_fetch_only: assert property (st && fn == 2'h0 && !status_pin |-> $past(first_fetch))
    else $error("status low without fetch");
  a_idle_high: assert property (st && fn == 2'h3 |-> status_pin)
    else $error("status not idle high");
  a_bit_time: assert property (ctl_r[0] && $changed(download_connector_port_transmit)
    |=> $stable(download_connector_port_transmit) [*7]) else $error("bit shorter than 8");
  c_download_connector_boot: cover property ($fell(core_rst) && program_mode);
  c_ack: cover property (fn == 2'h1 && !status_pin);
  c_async_tx: cover property (ctl_r[0] && $fell(download_connector_port_transmit));
endmodule
bind bmp_port bmp_port_chk u_chk (.*);
`default_nettype wire

// ===== bmp_host.sv
// host side of the programming cable
`timescale 1ns/1ps
`default_nettype none
module bmp_host (
  input wire logic attached,
  input wire logic host_clk,
  input wire logic tx,
  input wire logic clk_o,
  input wire logic clk_oe,
  output wire logic sel_0,
  output wire logic sel_1,
  output wire logic rx,
  output wire logic clk_i
);
  ////////////////////////////////
  // cable pulls both pins high, absent cable low
  assign sel_0 = attached;
  assign sel_1 = attached;
  // loopback through the cable
  assign rx = tx;
  assign clk_i = clk_oe ? clk_o : host_clk;
endmodule
`default_nettype wire

// ===== tb_boot_mode_programming_port.sv
// self-checking bench for the programming port
`timescale 1ns/1ps
`default_nettype none
module tb_boot_mode_programming_port;
  reg mclk = 1'h0;
  reg rst = 1'h1;
  reg rin_n = 1'h1;
  reg ff = 1'h0;
  reg ack = 1'h0;
  reg att = 1'h1;
  reg psel = 1'h0;
  reg penable = 1'h0;
  reg pwrite = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] rd;
  reg err;
  wire s0, s1, sp, pm, cb, crst, tx, rx, ck_i, ck_o, ck_oe, pready, pslverr;
  wire [15:0] sa;
  wire [31:0] prdata;
  integer fail_count = 0;
  integer n_checks = 0;
  integer i;
  initial forever #2 mclk = ~mclk;
  bmp_port dut (.mclk(mclk), .rst(rst), .ce(1'h1), .reset_in_n(rin_n),
    .startup_select_0(s0), .startup_select_1(s1), .first_fetch(ff), .int_ack(ack),
    .status_pin(sp), .program_mode(pm), .cold_boot(cb), .start_addr(sa), .core_rst(crst),
    .download_connector_port_transmit(tx), .download_connector_port_receive(rx), .download_connector_port_serial_clock_i(ck_i),
    .download_connector_port_serial_clock_o(ck_o), .download_connector_port_serial_clock_oe(ck_oe), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  bmp_host host (.attached(att), .host_clk(1'h0), .tx(tx), .clk_o(ck_o), .clk_oe(ck_oe),
    .sel_0(s0), .sel_1(s1), .rx(rx), .clk_i(ck_i));
  ////////////////////////////////
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task quit;
    begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'h1 && n < 20) begin
        n = n + 1;
        @(posedge mclk);
      end
      if (n == 20) quit;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task hold2;
    begin
      repeat (2) @(posedge mclk);
      #1;
    end
  endtask
  task poll(input integer b, input v, input integer lim);
    integer n;
    begin
      n = 0;
      apb(1'h0, 12'h008, 32'h0);
      while (rd[b] !== v && n < lim) begin
        n = n + 1;
        apb(1'h0, 12'h008, 32'h0);
      end
      if (n == lim) quit;
    end
  endtask
  ////////////////////////////////
  task t_boot(input sel);
    integer n;
    begin
      @(posedge mclk);
      att <= sel;
      rin_n <= 1'h0;
      repeat (8) @(posedge mclk);
      rin_n <= 1'h1;
      n = 0;
      while (crst !== 1'h0 && n < 20) begin
        n = n + 1;
        @(posedge mclk);
      end
      if (n == 20) quit;
      #1;
      chk("program_mode", 32'(pm), 32'(sel));
      chk("cold_boot", 32'(cb), 32'(sel));
      chk("start_addr", 32'(sa), 32'h0);
      apb(1'h0, 12'h000, 32'h0);
      chk("mode_reg", rd, {30'h0, sel, sel});
    end
  endtask
  task t_fetch;
    begin
      @(posedge mclk);
      ff <= 1'h1;
      @(posedge mclk);
      ff <= 1'h0;
      #1 chk("status_fetch", 32'(sp), 32'h0);
      @(posedge mclk);
      ff <= 1'h1;
      #1 chk("status_after", 32'(sp), 32'h1);
      @(posedge mclk);
      ff <= 1'h0;
      #1 chk("status_second", 32'(sp), 32'h1);
    end
  endtask
  task t_status;
    begin
      apb(1'h1, 12'h004, 32'h22);
      hold2;
      chk("gpo_low", 32'(sp), 32'h0);
      apb(1'h1, 12'h004, 32'h62);
      hold2;
      chk("gpo_high", 32'(sp), 32'h1);
      apb(1'h1, 12'h004, 32'h12);
      @(posedge mclk);
      ack <= 1'h1;
      hold2;
      chk("status_ack", 32'(sp), 32'h0);
      @(posedge mclk);
      ack <= 1'h0;
      hold2;
      chk("status_idle", 32'(sp), 32'h1);
      @(posedge mclk);
      ack <= 1'h1;
      apb(1'h1, 12'h004, 32'h32);
      hold2;
      chk("status_always_high", 32'(sp), 32'h1);
      @(posedge mclk);
      ack <= 1'h0;
    end
  endtask
  task t_async(input [31:0] c, input [7:0] exp);
    begin
      apb(1'h1, 12'h004, c);
      apb(1'h1, 12'h00C, 32'hA5);
      poll(2, 1'h1, 100);
      apb(1'h0, 12'h010, 32'h0);
      chk("rx_byte", {24'h0, rd[7:0]}, {24'h0, exp});
    end
  endtask
  task t_sync;
    integer n, k;
    reg prev;
    begin
      apb(1'h0, 12'h008, 32'h0);
      chk("gpio_in_low", 32'(rd[4]), 32'h0);
      apb(1'h1, 12'h004, 32'hD);
      hold2;
      chk("gpio_oe", 32'(ck_oe), 32'h1);
      chk("gpio_out", 32'(ck_o), 32'h1);
      apb(1'h0, 12'h008, 32'h0);
      chk("gpio_in_high", 32'(rd[4]), 32'h1);
      apb(1'h1, 12'h004, 32'h2);
      hold2;
      chk("sync_oe", 32'(ck_oe), 32'h1);
      apb(1'h1, 12'h00C, 32'h3C);
      k = 0;
      prev = ck_o;
      for (n = 0; n < 200; n = n + 1) begin
        @(posedge mclk);
        #1;
        if (ck_o === 1'h1 && prev === 1'h0) k = k + 1;
        prev = ck_o;
      end
      chk("sync_clocks", k, 32'h8);
      for (n = 0; n < 5; n = n + 1) apb(1'h1, 12'h00C, 32'h5A);
      apb(1'h0, 12'h008, 32'h0);
      chk("tx_full", 32'(rd[1]), 32'h1);
      poll(0, 1'h1, 300);
      apb(1'h0, 12'h0FC, 32'h0);
      chk("unmapped_err", 32'(err), 32'h1);
      chk("unmapped_rd", rd, 32'h0);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'h0;
    t_boot(1'h1);
    t_fetch;
    t_boot(1'h0);
    t_boot(1'h1);
    t_status;
    apb(1'h0, 12'h014, 32'h0);
    chk("baud_reset", rd, 32'h8);
    t_async(32'h3, 8'hA5);
    t_async(32'h1, 8'h25);
    t_sync;
    wrap_up;
  end
endmodule
`default_nettype wire
